/* verilog/erm_params.svh */
// Constants of the receive ring manager: register offsets, field bits,
// reset values and counts. Assumes a 32-bit APB slave, byte offsets.
`ifndef ERM_PARAMS_SVH
`define ERM_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ERM_OFS_START   8'h00
`define ERM_OFS_END     8'h04
`define ERM_OFS_REL_LO  8'h08
`define ERM_OFS_REL_HI  8'h0c
`define ERM_OFS_FILL    8'h10
`define ERM_OFS_RD_PTR  8'h14
`define ERM_OFS_DATA    8'h18
`define ERM_OFS_CTRL    8'h1c
`define ERM_OFS_FLAGS   8'h20
`define ERM_OFS_COUNT   8'h24

// ----------------------------------------------------------------
// Field bits and reset values
// ----------------------------------------------------------------
`define ERM_CTRL_AUTO   7
`define ERM_CTRL_DEC    6
`define ERM_CTRL_EN     0
`define ERM_FLAG_PEND   6
`define ERM_FLAG_ERR    0
`define ERM_RST_START   13'h0000
`define ERM_RST_END     13'h1fff
`define ERM_RST_PTR     13'h0000

// ----------------------------------------------------------------
// Status vector bits and counts
// ----------------------------------------------------------------
`define ERM_SV_LONG     16
`define ERM_SV_CARRIER  18
`define ERM_SV_CRC      20
`define ERM_SV_LENCHK   21
`define ERM_SV_TYPE     22
`define ERM_SV_OK       23
`define ERM_SV_MCAST    24
`define ERM_SV_BCAST    25
`define ERM_SV_DRIBBLE  26
`define ERM_SV_CTRL     27
`define ERM_SV_PAUSE    28
`define ERM_SV_UNKOP    29
`define ERM_SV_VLAN     30
`define ERM_TYPE_LIMIT  16'h05dc
`define ERM_TYPE_HI_POS 16'h000c
`define ERM_TYPE_LO_POS 16'h000d
`define ERM_HDR_BYTES   4'h6
`define ERM_HDR_LAST    3'h5
`define ERM_COUNT_MAX   8'hff
`define ERM_MEM_DEPTH   8192

`endif

/* verilog/erm_pkg.sv */
// Types of the receive ring manager.
// Assumes erm_params.svh for numeric constants.
package erm_pkg;
  typedef logic [12:0] erm_ptr_t;

  typedef enum logic [1:0] {
    ERM_IDLE = 2'b00,
    ERM_RECV = 2'b01,
    ERM_HDR  = 2'b11,
    ERM_DROP = 2'b10
  } erm_state_t;

  // One beat of the MAC receive path, sampled on a link clock rise
  typedef struct packed {
    logic       sof;
    logic       dv;
    logic [7:0] data;
    logic       eof;
    logic       fail;
    logic [2:0] extra_bits;
    logic       crc_err;
    logic       sym_err;
    logic       len_err;
    logic       bcast;
    logic       mcast;
    logic       ctrl;
    logic       pause;
    logic       unk_op;
    logic       vlan;
    logic       long_evt;
    logic       carrier;
  } erm_rx_link_t;
endpackage

/* verilog/erm_ring.sv */
// Receive ring manager: stores accepted frames with a six-byte header
// in a circular buffer, tracks fill/release pointers and frame count.
// Assumes an APB master on i_sys_clk and a MAC beat stream on i_rx_clk.
//
// Chosen here: the placing of the registers and register access over APB.
`include "erm_params.svh"
`timescale 1ns/1ps
`default_nettype none

module erm_ring (
  // Clock, reset, enable
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_clk_en,
  // APB slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // MAC receive link
  input  wire logic                  i_rx_clk,
  input  wire erm_pkg::erm_rx_link_t i_rx_link,
  // Status
  output logic                       o_frame_pending
);
  import erm_pkg::*;

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  function automatic erm_ptr_t ptr_inc(input erm_ptr_t p, input erm_ptr_t s,
                                       input erm_ptr_t e);
    return (p == e) ? s : p + 13'h0001;
  endfunction

  function automatic erm_ptr_t ptr_adv(input erm_ptr_t p, input erm_ptr_t s,
                                       input erm_ptr_t e, input logic [3:0] n);
    logic [13:0] sum;
    sum = {1'b0, p} + {10'h000, n};
    if (sum > {1'b0, e}) begin
      sum = sum - ({1'b0, e} - {1'b0, s} + 14'h0001);
    end
    return sum[12:0];
  endfunction

  function automatic logic [13:0] ptr_dist(input erm_ptr_t a, input erm_ptr_t b,
                                           input erm_ptr_t s, input erm_ptr_t e);
    if (b >= a) begin
      return {1'b0, b} - {1'b0, a};
    end
    return {1'b0, b} - {1'b0, a} + ({1'b0, e} - {1'b0, s} + 14'h0001);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]   mem [0:`ERM_MEM_DEPTH-1];
  erm_rx_link_t link_s1_reg, link_s2_reg;
  logic         rxc_s1_reg, rxc_s2_reg, rxc_s3_reg;
  erm_state_t   state_reg, state_next;
  erm_ptr_t     wr_ptr_reg, wr_ptr_next;
  erm_ptr_t     nxt_ptr_reg, nxt_ptr_next;
  erm_ptr_t     fill_reg, fill_next;
  erm_ptr_t     start_reg, start_next;
  erm_ptr_t     end_reg, end_next;
  erm_ptr_t     rel_reg, rel_next;
  erm_ptr_t     rd_ptr_reg, rd_ptr_next;
  logic [7:0]   rel_shadow_reg, rel_shadow_next;
  logic [15:0]  len_reg, len_next;
  logic [15:0]  type_reg, type_next;
  logic [31:0]  sv_reg, sv_next;
  logic [2:0]   hdr_idx_reg, hdr_idx_next;
  logic [7:0]   count_reg, count_next;
  logic         dropped_reg, dropped_next;
  logic         err_reg, err_next;
  logic         auto_reg, auto_next;
  logic         en_reg, en_next;
  logic         pready_reg, pready_next;
  logic         pslverr_reg, pslverr_next;
  logic [31:0]  prdata_reg, prdata_next;
  logic         pend_reg, pend_next;

  logic         mem_we;
  erm_ptr_t     mem_wa, pad_ptr;
  logic [7:0]   mem_wd;
  logic         rx_take, acc1, done, apb_wr, abort, err_set, err_clr;
  logic         dec_req, cnt_inc;
  logic [13:0]  room;
  erm_rx_link_t lk;

  assign lk      = link_s2_reg;
  assign rx_take = rxc_s2_reg & ~rxc_s3_reg;
  assign acc1    = i_psel & i_penable & ~pready_reg;
  assign done    = i_psel & i_penable & pready_reg;
  assign apb_wr  = done & i_pwrite;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next      = state_reg;
    wr_ptr_next     = wr_ptr_reg;
    nxt_ptr_next    = nxt_ptr_reg;
    fill_next       = fill_reg;
    start_next      = start_reg;
    end_next        = end_reg;
    rel_next        = rel_reg;
    rd_ptr_next     = rd_ptr_reg;
    rel_shadow_next = rel_shadow_reg;
    len_next        = len_reg;
    type_next       = type_reg;
    sv_next         = sv_reg;
    hdr_idx_next    = hdr_idx_reg;
    dropped_next    = dropped_reg;
    auto_next       = auto_reg;
    en_next         = en_reg;
    mem_we          = 1'b0;
    mem_wa          = wr_ptr_reg;
    mem_wd          = lk.data;
    abort           = 1'b0;
    cnt_inc         = 1'b0;
    err_clr         = 1'b0;
    dec_req         = 1'b0;
    pad_ptr         = wr_ptr_reg;
    room            = ptr_dist(fill_reg, rel_reg, start_reg, end_reg);

    unique case (state_reg)
      ERM_IDLE: begin
        if (rx_take && lk.sof && en_reg) begin
          if (count_reg == `ERM_COUNT_MAX) begin
            abort = 1'b1;
          end else if (room != 14'h0000 && room <= {10'h000, `ERM_HDR_BYTES}) begin
            abort = 1'b1;
          end else begin
            // Header space is skipped now and filled once status is known
            wr_ptr_next = ptr_adv(fill_reg, start_reg, end_reg, `ERM_HDR_BYTES);
            len_next    = 16'h0000;
            type_next   = 16'h0000;
            state_next  = ERM_RECV;
          end
        end
      end
      ERM_RECV: begin
        if (rx_take && lk.fail) begin
          state_next = ERM_IDLE;
        end else if (rx_take && lk.dv) begin
          if (wr_ptr_reg == rel_reg) begin
            abort = 1'b1;
          end else begin
            mem_we      = 1'b1;
            wr_ptr_next = ptr_inc(wr_ptr_reg, start_reg, end_reg);
            len_next    = len_reg + 16'h0001;
            if (len_reg == `ERM_TYPE_HI_POS) begin
              type_next[15:8] = lk.data;
            end
            if (len_reg == `ERM_TYPE_LO_POS) begin
              type_next[7:0] = lk.data;
            end
          end
        end else if (rx_take && lk.eof) begin
          // Odd next address gets one pad byte so frames start even
          if (wr_ptr_reg[0]) begin
            pad_ptr = ptr_inc(wr_ptr_reg, start_reg, end_reg);
          end
          if (pad_ptr == rel_reg || (wr_ptr_reg[0] && wr_ptr_reg == rel_reg)) begin
            abort = 1'b1;
          end else begin
            nxt_ptr_next                = pad_ptr;
            sv_next                     = 32'h0000_0000;
            sv_next[15:0]               = len_reg;
            sv_next[`ERM_SV_LONG]       = lk.long_evt | dropped_reg;
            sv_next[`ERM_SV_CARRIER]    = lk.carrier;
            sv_next[`ERM_SV_CRC]        = lk.crc_err;
            sv_next[`ERM_SV_LENCHK]     = lk.len_err;
            sv_next[`ERM_SV_TYPE]       = type_reg > `ERM_TYPE_LIMIT;
            sv_next[`ERM_SV_OK]         = ~lk.crc_err & ~lk.sym_err;
            sv_next[`ERM_SV_MCAST]      = lk.mcast;
            sv_next[`ERM_SV_BCAST]      = lk.bcast;
            // Extra bits are only reported; they never reach the buffer
            sv_next[`ERM_SV_DRIBBLE]    = lk.extra_bits != 3'h0;
            sv_next[`ERM_SV_CTRL]       = lk.ctrl;
            sv_next[`ERM_SV_PAUSE]      = lk.pause;
            sv_next[`ERM_SV_UNKOP]      = lk.unk_op;
            sv_next[`ERM_SV_VLAN]       = lk.vlan;
            wr_ptr_next                 = fill_reg;
            hdr_idx_next                = 3'h0;
            state_next                  = ERM_HDR;
          end
        end
      end
      ERM_HDR: begin
        mem_we = 1'b1;
        case (hdr_idx_reg)
          3'h0:    mem_wd = nxt_ptr_reg[7:0];
          3'h1:    mem_wd = {3'b000, nxt_ptr_reg[12:8]};
          3'h2:    mem_wd = sv_reg[7:0];
          3'h3:    mem_wd = sv_reg[15:8];
          3'h4:    mem_wd = sv_reg[23:16];
          default: mem_wd = sv_reg[31:24];
        endcase
        wr_ptr_next  = ptr_inc(wr_ptr_reg, start_reg, end_reg);
        hdr_idx_next = hdr_idx_reg + 3'h1;
        if (hdr_idx_reg == `ERM_HDR_LAST) begin
          fill_next    = nxt_ptr_reg;
          cnt_inc      = 1'b1;
          dropped_next = 1'b0;
          state_next   = ERM_IDLE;
        end
      end
      ERM_DROP: begin
        if (rx_take && (lk.eof || lk.fail)) begin
          state_next = ERM_IDLE;
        end
      end
    endcase

    if (abort) begin
      state_next   = ERM_DROP;
      dropped_next = 1'b1;
    end
    err_set = abort;

    // APB: effects land on the edge where the master sees pready
    pready_next  = acc1;
    pslverr_next = 1'b0;
    prdata_next  = 32'h0000_0000;
    if (acc1) begin
      case (i_paddr)
        `ERM_OFS_START:  prdata_next[12:0] = start_reg;
        `ERM_OFS_END:    prdata_next[12:0] = end_reg;
        `ERM_OFS_REL_LO: prdata_next[7:0]  = rel_reg[7:0];
        `ERM_OFS_REL_HI: prdata_next[4:0]  = rel_reg[12:8];
        `ERM_OFS_FILL:   prdata_next[12:0] = fill_reg;
        `ERM_OFS_RD_PTR: prdata_next[12:0] = rd_ptr_reg;
        `ERM_OFS_DATA:   prdata_next[7:0]  = mem[rd_ptr_reg];
        `ERM_OFS_CTRL: begin
          prdata_next[`ERM_CTRL_AUTO] = auto_reg;
          prdata_next[`ERM_CTRL_EN]   = en_reg;
        end
        `ERM_OFS_FLAGS: begin
          prdata_next[`ERM_FLAG_PEND] = pend_reg;
          prdata_next[`ERM_FLAG_ERR]  = err_reg;
        end
        `ERM_OFS_COUNT:  prdata_next[7:0]  = count_reg;
        default:         pslverr_next      = 1'b1;
      endcase
    end
    if (done && !i_pwrite && i_paddr == `ERM_OFS_DATA && auto_reg) begin
      rd_ptr_next = ptr_inc(rd_ptr_reg, start_reg, end_reg);
    end
    if (apb_wr) begin
      case (i_paddr)
        `ERM_OFS_START: begin
          start_next = i_pwdata[12:0];
          // Pointer configuration: fill restarts at the region start only while en_reg is clear
          if (!en_reg) begin
            fill_next = i_pwdata[12:0];
          end
        end
        `ERM_OFS_END:    end_next        = i_pwdata[12:0];
        `ERM_OFS_REL_LO: rel_shadow_next = i_pwdata[7:0];
        `ERM_OFS_REL_HI: rel_next        = {i_pwdata[4:0], rel_shadow_reg};
        `ERM_OFS_RD_PTR: rd_ptr_next     = i_pwdata[12:0];
        `ERM_OFS_CTRL: begin
          auto_next = i_pwdata[`ERM_CTRL_AUTO];
          en_next   = i_pwdata[`ERM_CTRL_EN];
          dec_req   = i_pwdata[`ERM_CTRL_DEC];
        end
        `ERM_OFS_FLAGS:  err_clr = i_pwdata[`ERM_FLAG_ERR];
        default: ;
      endcase
    end

    // Set wins over a same-cycle clear
    err_next   = (err_reg & ~err_clr) | err_set;
    count_next = count_reg + {7'h00, cnt_inc}
               - {7'h00, dec_req && count_reg != 8'h00};
    pend_next  = count_next != 8'h00;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_s1_reg    <= '0;
      link_s2_reg    <= '0;
      rxc_s1_reg     <= 1'b0;
      rxc_s2_reg     <= 1'b0;
      rxc_s3_reg     <= 1'b0;
      state_reg      <= ERM_IDLE;
      wr_ptr_reg     <= `ERM_RST_PTR;
      nxt_ptr_reg    <= `ERM_RST_PTR;
      fill_reg       <= `ERM_RST_PTR;
      start_reg      <= `ERM_RST_START;
      end_reg        <= `ERM_RST_END;
      rel_reg        <= `ERM_RST_PTR;
      rd_ptr_reg     <= `ERM_RST_PTR;
      rel_shadow_reg <= 8'h00;
      len_reg        <= 16'h0000;
      type_reg       <= 16'h0000;
      sv_reg         <= 32'h0000_0000;
      hdr_idx_reg    <= 3'h0;
      count_reg      <= 8'h00;
      dropped_reg    <= 1'b0;
      err_reg        <= 1'b0;
      auto_reg       <= 1'b0;
      en_reg         <= 1'b0;
      pready_reg     <= 1'b0;
      pslverr_reg    <= 1'b0;
      prdata_reg     <= 32'h0000_0000;
      pend_reg       <= 1'b0;
    end else if (i_clk_en) begin
      link_s1_reg    <= i_rx_link;
      link_s2_reg    <= link_s1_reg;
      rxc_s1_reg     <= i_rx_clk;
      rxc_s2_reg     <= rxc_s1_reg;
      rxc_s3_reg     <= rxc_s2_reg;
      state_reg      <= state_next;
      wr_ptr_reg     <= wr_ptr_next;
      nxt_ptr_reg    <= nxt_ptr_next;
      fill_reg       <= fill_next;
      start_reg      <= start_next;
      end_reg        <= end_next;
      rel_reg        <= rel_next;
      rd_ptr_reg     <= rd_ptr_next;
      rel_shadow_reg <= rel_shadow_next;
      len_reg        <= len_next;
      type_reg       <= type_next;
      sv_reg         <= sv_next;
      hdr_idx_reg    <= hdr_idx_next;
      count_reg      <= count_next;
      dropped_reg    <= dropped_next;
      err_reg        <= err_next;
      auto_reg       <= auto_next;
      en_reg         <= en_next;
      pready_reg     <= pready_next;
      pslverr_reg    <= pslverr_next;
      prdata_reg     <= prdata_next;
      pend_reg       <= pend_next;
    end
  end

  assign o_prdata        = prdata_reg;
  assign o_pready        = pready_reg;
  assign o_pslverr       = pslverr_reg;
  assign o_frame_pending = pend_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n || !i_clk_en);

  apb_answer_a: assert property (acc1 |=> o_pready ##1 !o_pready)
    else $error("APB answer not one cycle");
  no_rel_write_a: assert property (mem_we |-> mem_wa != rel_reg)
    else $error("Wrote release location");
  fill_gap_a: assert property ((state_reg == ERM_HDR && hdr_idx_reg == `ERM_HDR_LAST)
    |=> fill_reg != rel_reg)
    else $error("Fill reached release");
  fill_hold_a: assert property ((state_reg == ERM_RECV && !apb_wr)
    |=> $stable(fill_reg))
    else $error("Fill moved mid frame");
  rel_read_a: assert property ((acc1 && !i_pwrite && i_paddr == `ERM_OFS_REL_LO)
    |=> o_prdata == {24'h00_0000, rel_reg[7:0]})
    else $error("Release read not committed value");
  rel_commit_a: assert property ((apb_wr && i_paddr == `ERM_OFS_REL_HI)
    |=> rel_reg == {$past(i_pwdata[4:0]), $past(rel_shadow_reg)})
    else $error("Release commit wrong");
  dec_floor_a: assert property ((dec_req && count_reg == 8'h00 && !cnt_inc)
    |=> count_reg == 8'h00 && !o_frame_pending)
    else $error("Count went below zero");
  full_abort_a: assert property ((state_reg == ERM_IDLE && rx_take && lk.sof && en_reg
    && count_reg == `ERM_COUNT_MAX) |=> state_reg == ERM_DROP && err_reg)
    else $error("Full count did not abort");
  auto_adv_a: assert property ((done && !i_pwrite && i_paddr == `ERM_OFS_DATA && auto_reg)
    |=> rd_ptr_reg == ptr_inc($past(rd_ptr_reg), start_reg, end_reg))
    else $error("Read pointer did not advance");
  hdr_len_a: assert property ((state_reg == ERM_RECV ##1 state_reg == ERM_HDR)
    |-> (state_reg == ERM_HDR)[*6] ##1 state_reg == ERM_IDLE)
    else $error("Header not six bytes");

  frame_done_c: cover property (state_reg == ERM_HDR ##1 state_reg == ERM_IDLE);
  overrun_c: cover property (state_reg == ERM_RECV ##1 state_reg == ERM_DROP);
  rd_wrap_c: cover property (done && auto_reg && rd_ptr_reg == end_reg
    && i_paddr == `ERM_OFS_DATA);
endmodule

`default_nettype wire

/* dv/erm_mac_model.sv */
// MAC receive side model: sends frames as link beats.
// Assumes the bench calls send() from one thread at a time.
`timescale 1ns/1ps
`default_nettype none
module erm_mac_model (
  // Link
  output var logic                  o_rx_clk,
  output var erm_pkg::erm_rx_link_t o_rx_link
);
  import erm_pkg::*;
  initial begin
    o_rx_clk = 1'b0;
    o_rx_link = '0;
  end
  // Fields change while low; clock stands still between frames
  task automatic beat(input erm_rx_link_t b);
    o_rx_link = b;
    #80 o_rx_clk = 1'b1;
    #80 o_rx_clk = 1'b0;
  endtask
  task automatic send(input logic [7:0] d[$], input erm_rx_link_t st);
    erm_rx_link_t b;
    b = '0;
    b.sof = 1'b1;
    beat(b);
    foreach (d[i]) begin
      b = '0;
      b.dv = 1'b1;
      b.data = d[i];
      beat(b);
    end
    b = st;
    b.eof = 1'b1;
    beat(b);
    // Released data must not keep showing the last byte
    b = '0;
    b.data = ~d[d.size() - 1];
    o_rx_link = b;
  endtask
endmodule
`default_nettype wire

/* dv/test_ethernet_rx_ring_manager.sv */
// Bench for the ring manager: APB host tasks and a byte ring model.
// Assumes erm_ring and erm_mac_model.
`include "erm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_ethernet_rx_ring_manager;
  import erm_pkg::*;
  logic         i_sys_clk = 1'b0;
  logic         i_reset_n = 1'b0;
  logic         psel      = 1'b0;
  logic         penable   = 1'b0;
  logic         pwrite    = 1'b0;
  logic [7:0]   paddr     = 8'h00;
  logic [31:0]  pwdata    = 32'h0000_0000;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         pend;
  logic         rx_clk;
  erm_rx_link_t rx_link;
  logic [7:0]   mem [8192];
  int           start_p = 0;
  int           end_p = 8191;
  int           fill = 0;
  int           rel = 0;
  int           cnt = 0;
  logic         err = 1'b0;
  logic         drop_seen = 1'b0;
  int           errors = 0;
  int           samples_checked = 0;
  logic [31:0]  r;
  logic         e;
  always #10 i_sys_clk = ~i_sys_clk;
  erm_mac_model u_mac (.o_rx_clk(rx_clk), .o_rx_link(rx_link));
  erm_ring u_dut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_rx_clk(rx_clk), .i_rx_link(rx_link), .o_frame_pending(pend)
  );
  // ------------
  // Host tasks
  // ------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask
  function automatic int wrp(input int p);
    return (p > end_p) ? p - (end_p - start_p + 1) : p;
  endfunction
  task automatic stat();
    rdc(`ERM_OFS_COUNT, 32'(cnt));
    rdc(`ERM_OFS_FILL, 32'(fill));
    rdc(`ERM_OFS_COUNT, 32'(cnt));
    rdc(`ERM_OFS_FLAGS, {25'h0, cnt != 0, 5'h0, err});
    chk(32'(pend), 32'(cnt != 0));
  endtask
  task automatic release_to(input int p);
    apb(1'b1, `ERM_OFS_REL_LO, 32'(p & 255));
    rdc(`ERM_OFS_REL_LO, 32'(rel & 255));
    rdc(`ERM_OFS_REL_HI, 32'(rel >> 8));
    apb(1'b1, `ERM_OFS_REL_HI, 32'(p >> 8));
    rel = p;
    rdc(`ERM_OFS_REL_LO, 32'(rel & 255));
  endtask
  task automatic frame(input int n);
    logic [7:0] d[$];
    erm_rx_link_t st;
    logic [31:0] sv;
    int nx, fr, p;
    d = {};
    for (int i = 0; i < n; i++) d.push_back(8'($urandom));
    st = erm_rx_link_t'({12'h000, 14'($urandom)});
    sv = {1'b0, st.vlan, st.unk_op, st.pause, st.ctrl, |st.extra_bits, st.bcast,
          st.mcast, !(st.crc_err | st.sym_err), (n > 13 && {d[12], d[13]} > 16'd1500),
          st.len_err, st.crc_err, 1'b0, st.carrier, 1'b0, st.long_evt | drop_seen, 16'(n)};
    fr = (rel > fill) ? rel - fill - 1 : (end_p - start_p) - (fill - rel);
    nx = wrp(fill + 6 + n);
    nx = wrp(nx + nx % 2);
    p = fill;
    if (cnt == 255 || 6 + n + n % 2 > fr) begin
      err = 1'b1;
      drop_seen = 1'b1;
    end else begin
      for (int i = 0; i < 6 + n; i++) begin
        mem[p] = (i < 2) ? 8'(nx >> (8 * i)) : (i < 6) ? 8'(sv >> (8 * (i - 2))) : d[i - 6];
        p = wrp(p + 1);
      end
      p = fill;
      fill = nx;
      cnt++;
      drop_seen = 1'b0;
    end
    u_mac.send(d, st);
    repeat (16) @(posedge i_sys_clk);
    stat();
    if (fill == nx) begin
      apb(1'b1, `ERM_OFS_RD_PTR, 32'(p));
      repeat (6 + n) begin
        rdc(`ERM_OFS_DATA, 32'(mem[p]));
        p = wrp(p + 1); // checked by the next read in the loop
      end
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------
  // Sequence
  // ------------
  initial begin
    void'($urandom(59));
    repeat (8) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    rdc(`ERM_OFS_START, 32'h0000_0000);
    rdc(`ERM_OFS_END, 32'h0000_1fff);
    stat();
    apb(1'b0, 8'h28, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    apb(1'b1, `ERM_OFS_END, 32'h0000_007f);
    end_p = 127;
    release_to(64);
    apb(1'b1, `ERM_OFS_CTRL, 32'h0000_0081);
    for (int i = 0; i < 12; i++) begin
      frame(14 + $urandom % 30);
      if (err) begin
        apb(1'b1, `ERM_OFS_FLAGS, 32'h0000_0001);
        err = 1'b0;
        release_to((fill == start_p) ? end_p : fill - 1);
      end
      apb(1'b1, `ERM_OFS_CTRL, 32'h0000_00c1);
      if (cnt > 0) cnt--;
      stat();
    end
    // Small frames keep the long count run short
    apb(1'b1, `ERM_OFS_CTRL, 32'h0000_0080);
    apb(1'b1, `ERM_OFS_START, 32'h0000_0000);
    fill = 0;
    apb(1'b1, `ERM_OFS_END, 32'h0000_1fff);
    end_p = 8191;
    release_to(8191);
    apb(1'b1, `ERM_OFS_CTRL, 32'h0000_0081);
    while (cnt < 256) begin
      frame(2);
      if (err) cnt = 256;
    end
    give_verdict();
  end
  initial begin
    #(20 * 90000);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
